// ### core/iox_core.sv
// top of the sixteen-bit i2c io expander: bus slave, register file, port pins
`timescale 1ns/1ps
`default_nettype none
module iox_core
   import iox_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output var  logic       sda_out,
   output var  logic       sda_oe_out,
   input  wire logic       addr_strap_bit0_in,
   input  wire logic       addr_strap_bit1_in,
   input  wire logic       addr_strap_bit2_in,
   input  wire logic [7:0] port_zero_pins_in,
   input  wire logic [7:0] port_one_pins_in,
   output var  logic [7:0] port_zero_pins_out,
   output var  logic [7:0] port_zero_pins_oe_out,
   output var  logic [7:0] port_one_pins_out,
   output var  logic [7:0] port_one_pins_oe_out
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   iox_regs_t   regs;
   iox_regs_t   next_regs;
   iox_link_t   link;
   iox_link_t   next_link;
   logic [15:0] pins_sync;
   logic        wr_tog_sync;
   logic [2:0]  strap_sync;
   logic [63:0] image_meta;
   logic [63:0] image_sync;
   logic        start_det;
   logic        start_mark;
   logic        stop_det;
   logic [15:0] pin_out_all;
   logic [15:0] pin_oe_all;
   logic [7:0]  rx_byte;
   logic [6:0]  own_addr;
   logic [2:0]  cmd_other;
   logic        dev_ack_slot;

   // ****************************************************************
   // synchronisers into the core clock and the link clock
   // ****************************************************************
   // port pins are sampled twice before any register sees them
   iox_sync2 #(.WIDTH(16)) u_pin_sync (
      .clk_in (clk_in),
      .d_in   ({port_one_pins_in, port_zero_pins_in}),
      .q_out  (pins_sync)
   );

   // write event toggle from the link side
   iox_sync2 #(.WIDTH(1)) u_wr_sync (
      .clk_in (clk_in),
      .d_in   (link.wr_tog),
      .q_out  (wr_tog_sync)
   );

   // straps settle long before the eighth address bit is compared
   iox_sync2 #(.WIDTH(3)) u_strap_sync (
      .clk_in (scl_in),
      .d_in   ({addr_strap_bit2_in, addr_strap_bit1_in, addr_strap_bit0_in}),
      .q_out  (strap_sync)
   );

   // ****************************************************************
   // core clock: register file
   // ****************************************************************
   // next state of the register file
   always_comb begin
      next_regs         = regs;
      next_regs.wr_seen = wr_tog_sync;
      // input pins only get inverted; output pins report their true level
      next_regs.level   = pins_sync ^ (regs.invert & regs.direction);
      // a toggle edge means link.wr has been stable for at least two clocks
      if (wr_tog_sync != regs.wr_seen) begin
         unique case (link.wr.idx)
            IOX_REG_OUTPUT_LATCH_PORT0:  next_regs.latch[7:0]      = link.wr.data;
            IOX_REG_OUTPUT_LATCH_PORT1:  next_regs.latch[15:8]     = link.wr.data;
            IOX_REG_INVERT_SELECT_PORT0: next_regs.invert[7:0]     = link.wr.data;
            IOX_REG_INVERT_SELECT_PORT1: next_regs.invert[15:8]    = link.wr.data;
            IOX_REG_DIRECTION_PORT0:     next_regs.direction[7:0]  = link.wr.data;
            IOX_REG_DIRECTION_PORT1:     next_regs.direction[15:8] = link.wr.data;
            IOX_REG_INPUT_LEVEL_PORT0,
            IOX_REG_INPUT_LEVEL_PORT1:   next_regs.level           = next_regs.level;
         endcase
      end
      // read image, indexed by command: latch reads back the flip-flops
      next_regs.image = {regs.direction[15:8], regs.direction[7:0],
                         regs.invert[15:8], regs.invert[7:0],
                         regs.latch[15:8], regs.latch[7:0],
                         regs.level[15:8], regs.level[7:0]};
   end

   // register the file; reset values are the defaults
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         regs.latch     <= {IOX_RST_OUTPUT_LATCH, IOX_RST_OUTPUT_LATCH};
         regs.invert    <= {IOX_RST_INVERT_SELECT, IOX_RST_INVERT_SELECT};
         regs.direction <= {IOX_RST_DIRECTION, IOX_RST_DIRECTION};
         regs.level     <= '0;
         regs.wr_seen   <= 1'b0;
         regs.image     <= '0;
      end else begin
         regs <= next_regs;
      end
   end

   // ****************************************************************
   // port pin drivers
   // ****************************************************************
   iox_port_pins #(.PINS(IOX_PIN_COUNT)) u_pins (
      .clk_in       (clk_in),
      .rst_in       (rst_in),
      .latch_in     (regs.latch),
      .direction_in (regs.direction),
      .pin_out      (pin_out_all),
      .pin_oe_out   (pin_oe_all)
   );

   // split into the two ports; all bits come from driver flip-flops
   assign port_zero_pins_out    = pin_out_all[7:0];
   assign port_one_pins_out     = pin_out_all[15:8];
   assign port_zero_pins_oe_out = pin_oe_all[7:0];
   assign port_one_pins_oe_out  = pin_oe_all[15:8];

   // ****************************************************************
   // link clock: start and stop detection
   // ****************************************************************
   // start: sda falls while scl is high; cleared once the frame has seen it
   always_ff @(negedge sda_in or posedge rst_in or posedge start_mark) begin
      if (rst_in || start_mark) begin
         start_det <= 1'b0;
      end else begin
         start_det <= scl_in;
      end
   end

   // stop: sda rises while scl is high; the next start clears it at once,
   // since the start mark is held low for as long as a stop stands
   always_ff @(posedge sda_in or posedge rst_in or posedge start_det) begin
      if (rst_in || start_det) begin
         stop_det <= 1'b0;
      end else if (scl_in) begin
         stop_det <= 1'b1;
      end
   end

   // image words settle while the address byte is clocked in
   always_ff @(posedge scl_in) begin
      image_meta <= regs.image;
      image_sync <= image_meta;
   end

   // ****************************************************************
   // link clock: byte engine on the rising scl edge
   // ****************************************************************
   assign rx_byte   = {link.shreg[6:0], sda_in};
   assign own_addr  = {IOX_ADDR_FIXED, strap_sync};
   assign cmd_other = {link.cmd[2:1], ~link.cmd[0]};

   // next state of the link; sda is stable here, sampled on the rising edge
   always_comb begin
      next_link         = link;
      next_link.bit_cnt = link.bit_cnt + 4'h1;
      next_link.shreg   = rx_byte;
      next_link.txreg   = {link.txreg[6:0], 1'b1};
      if (start_mark) begin
         // first address bit arrives on the first rising edge after start
         next_link.state   = IOX_ADDR;
         next_link.bit_cnt = 4'h1;
         next_link.shreg   = {7'h00, sda_in};
      end else begin
         unique case (link.state)
            IOX_IDLE: begin
               next_link.bit_cnt = '0;
            end
            IOX_ADDR: begin
               if (link.bit_cnt == IOX_LAST_DATA_BIT) begin
                  // msb first; general call never matches
                  if (rx_byte[7:1] == own_addr && rx_byte[7:1] != IOX_GENERAL_CALL) begin
                     next_link.state = IOX_ADDR_ACK;
                  end else begin
                     next_link.state = IOX_IDLE;
                  end
               end
            end
            IOX_ADDR_ACK: begin
               next_link.bit_cnt = '0;
               if (link.shreg[0]) begin
                  next_link.state = IOX_RD;
                  next_link.txreg = image_sync[{link.cmd, 3'h0} +: 8];
               end else begin
                  next_link.state = IOX_CMD;
               end
            end
            IOX_CMD: begin
               if (link.bit_cnt == IOX_LAST_DATA_BIT) begin
                  next_link.state = IOX_CMD_ACK;
                  next_link.cmd   = rx_byte[2:0];
               end
            end
            IOX_CMD_ACK: begin
               next_link.bit_cnt = '0;
               next_link.state   = IOX_WR;
            end
            IOX_WR: begin
               if (link.bit_cnt == IOX_LAST_DATA_BIT) begin
                  // publish the byte; it holds until the next byte completes
                  next_link.state    = IOX_WR_ACK;
                  next_link.wr.idx   = link.cmd;
                  next_link.wr.data  = rx_byte;
                  next_link.wr_tog   = ~link.wr_tog;
               end
            end
            IOX_WR_ACK: begin
               next_link.bit_cnt = '0;
               next_link.state   = IOX_WR;
               next_link.cmd     = cmd_other;
            end
            IOX_RD: begin
               if (link.bit_cnt == IOX_LAST_DATA_BIT) begin
                  next_link.state = IOX_RD_ACK;
               end
            end
            IOX_RD_ACK: begin
               // pointer moves to the other register of the pair, even on a nack
               next_link.bit_cnt = '0;
               next_link.cmd     = cmd_other;
               if (!sda_in) begin
                  next_link.state = IOX_RD;
                  next_link.txreg = image_sync[{cmd_other, 3'h0} +: 8];
               end else begin
                  next_link.state = IOX_IDLE;
               end
            end
         endcase
         // a stop ends the frame; the engine waits for the next start
         if (stop_det) begin
            next_link.state = IOX_IDLE;
         end
      end
   end

   // register the link state; the core reset also clears the link
   always_ff @(posedge scl_in or posedge rst_in) begin
      if (rst_in) begin
         link.state   <= IOX_IDLE;
         link.bit_cnt <= '0;
         link.shreg   <= '0;
         link.txreg   <= '0;
         link.cmd     <= IOX_RST_CMD;
         link.wr_tog  <= 1'b0;
         link.wr      <= '0;
      end else begin
         link <= next_link;
      end
   end

   // ****************************************************************
   // link clock: sda driver on the falling scl edge
   // ****************************************************************
   assign dev_ack_slot = (link.state == IOX_ADDR_ACK) || (link.state == IOX_CMD_ACK) ||
                         (link.state == IOX_WR_ACK);

   // sda moves only after scl falls, so it is stable across the high phase
   always_ff @(negedge scl_in or posedge rst_in or posedge stop_det) begin
      if (rst_in || stop_det) begin
         sda_oe_out <= 1'b0;
         sda_out    <= 1'b0;
         start_mark <= 1'b0;
      end else begin
         sda_out    <= 1'b0;                                          // open drain: low or released
         start_mark <= start_det;
         // ack low for the whole ninth clock; released in the master ack slot
         sda_oe_out <= dev_ack_slot ||
                       ((link.state == IOX_RD) && !link.txreg[7]);
      end
   end

endmodule : iox_core
`default_nettype wire

// ### core/iox_port_pins.sv
// per-pin push-pull driver control for the sixteen port pins
`timescale 1ns/1ps
`default_nettype none
module iox_port_pins
   import iox_pkg::*;
#(
   parameter int PINS = IOX_PIN_COUNT
) (
   input  wire logic            clk_in,
   input  wire logic            rst_in,
   input  wire logic [PINS-1:0] latch_in,
   input  wire logic [PINS-1:0] direction_in,
   output var  logic [PINS-1:0] pin_out,
   output var  logic [PINS-1:0] pin_oe_out
);
   logic [PINS-1:0] high_side_driver;
   logic [PINS-1:0] low_side_driver;

   // one driver pair per pin; reset leaves both off, as every pin is an input
   for (genvar i = 0; i < PINS; i++) begin : g_pin
      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            high_side_driver[i] <= 1'b0;
            low_side_driver[i]  <= 1'b0;
         end else begin
            high_side_driver[i] <= ~direction_in[i] & latch_in[i];
            low_side_driver[i]  <= ~direction_in[i] & ~latch_in[i];
         end
      end
      assign pin_out[i]    = high_side_driver[i];
      assign pin_oe_out[i] = high_side_driver[i] | low_side_driver[i];
   end
endmodule : iox_port_pins
`default_nettype wire

// ### core/iox_sync2.sv
// two flip-flop synchroniser for a bus of independent levels
`timescale 1ns/1ps
`default_nettype none
module iox_sync2
   import iox_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_in,
   input  wire logic [WIDTH-1:0] d_in,
   output var  logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk_in) begin
      meta  <= d_in;
      q_out <= meta;
   end
endmodule : iox_sync2
`default_nettype wire

// ### inc/iox_pkg.sv
// package: constants, types and register map of the sixteen-bit i2c io expander
package iox_pkg;

   // ****************************************************************
   // register indices selected by the command byte
   // ****************************************************************
   localparam logic [2:0] IOX_REG_INPUT_LEVEL_PORT0  = 3'h0;
   localparam logic [2:0] IOX_REG_INPUT_LEVEL_PORT1  = 3'h1;
   localparam logic [2:0] IOX_REG_OUTPUT_LATCH_PORT0 = 3'h2;
   localparam logic [2:0] IOX_REG_OUTPUT_LATCH_PORT1 = 3'h3;
   localparam logic [2:0] IOX_REG_INVERT_SELECT_PORT0 = 3'h4;
   localparam logic [2:0] IOX_REG_INVERT_SELECT_PORT1 = 3'h5;
   localparam logic [2:0] IOX_REG_DIRECTION_PORT0    = 3'h6;
   localparam logic [2:0] IOX_REG_DIRECTION_PORT1    = 3'h7;

   // ****************************************************************
   // values after reset
   // ****************************************************************
   localparam logic [7:0] IOX_RST_OUTPUT_LATCH  = 8'hff;
   localparam logic [7:0] IOX_RST_INVERT_SELECT = 8'h00;
   localparam logic [7:0] IOX_RST_DIRECTION     = 8'hff;
   localparam logic [2:0] IOX_RST_CMD           = 3'h0;

   // ****************************************************************
   // bus addressing and bit counting
   // ****************************************************************
   localparam logic [3:0] IOX_ADDR_FIXED    = 4'h4;  // upper address bits 0100
   localparam logic [6:0] IOX_GENERAL_CALL  = 7'h00;
   localparam logic [3:0] IOX_LAST_DATA_BIT = 4'h7;  // eighth bit of a byte
   localparam int         IOX_PORT_BITS     = 8;
   localparam int         IOX_PIN_COUNT     = 16;

   // ****************************************************************
   // link state machine
   // ****************************************************************
   typedef enum logic [3:0] {
      IOX_IDLE,
      IOX_ADDR,
      IOX_ADDR_ACK,
      IOX_CMD,
      IOX_CMD_ACK,
      IOX_WR,
      IOX_WR_ACK,
      IOX_RD,
      IOX_RD_ACK
   } iox_link_state_t;

   // one register write passed from the link to the core clock
   typedef struct packed {
      logic [2:0] idx;
      logic [7:0] data;
   } iox_wr_t;

   // link side state, clocked by the rising scl edge
   typedef struct packed {
      iox_link_state_t state;
      logic [3:0]      bit_cnt;
      logic [7:0]      shreg;
      logic [7:0]      txreg;
      logic [2:0]      cmd;
      logic            wr_tog;
      iox_wr_t         wr;
   } iox_link_t;

   // core side register file
   typedef struct packed {
      logic [15:0] latch;
      logic [15:0] invert;
      logic [15:0] direction;
      logic [15:0] level;
      logic        wr_seen;
      logic [63:0] image;
   } iox_regs_t;

endpackage : iox_pkg

// ### tb/iox_core_bench.sv
// self-checking bench for the io expander
`timescale 1ns/1ps
`default_nettype none
module iox_core_bench;
   import iox_pkg::*;
   localparam logic [6:0] DEV = {IOX_ADDR_FIXED, 3'b101};
   logic       clk_in, rst_in, scl, m_low, s_o, s_oe, ak;
   logic [7:0] e0, e1, p0, p1, z_o, z_oe, o_o, o_oe, q;
   logic [7:0] reg_m [8];
   wire logic  sda_w;
   int         failures, tests_run;
   // pulled-up sda; pins echo whatever the device drives
   assign sda_w = ~(m_low | (s_oe & ~s_o));
   assign p0    = (z_oe & z_o) | (~z_oe & e0);
   assign p1    = (o_oe & o_o) | (~o_oe & e1);
   iox_core i_iox_core (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_w), .sda_out(s_o),
      .sda_oe_out(s_oe), .addr_strap_bit0_in(1'b1), .addr_strap_bit1_in(1'b0), .addr_strap_bit2_in(1'b1),
      .port_zero_pins_in(p0), .port_one_pins_in(p1), .port_zero_pins_out(z_o), .port_zero_pins_oe_out(z_oe),
      .port_one_pins_out(o_o), .port_one_pins_oe_out(o_oe));
   iox_master i_iox_master (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda_w));
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // ************************************************
   // shared tasks
   // ************************************************
   task automatic chk(input logic [7:0] s, input logic [7:0] x);
      tests_run++;
      if (s !== x) begin
         failures++;
         $display("BAD %0t seen %h want %h", $time, s, x);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   // output pins report the driven level, inputs the inverted choice
   function automatic logic [7:0] lvl(input int p, input logic [7:0] e);
      return (~reg_m[6+p] & reg_m[2+p]) | (reg_m[6+p] & (e ^ reg_m[4+p]));
   endfunction : lvl
   task automatic do_reset();
      @(posedge clk_in);
      #2 rst_in = 1'b1;
      reg_m = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
      repeat (3) @(posedge clk_in);
      #2 rst_in = 1'b0;
      repeat (4) @(posedge clk_in);
   endtask : do_reset
   task automatic addr(input logic rd, input logic [6:0] a, input logic acc);
      i_iox_master.start();
      i_iox_master.xfer({a, rd}, 1'b1, q, ak);
      chk({7'h0, ak}, {7'h0, ~acc});
   endtask : addr
   task automatic setcmd(input logic [7:0] c);
      addr(1'b0, DEV, 1'b1);
      i_iox_master.xfer(c, 1'b1, q, ak);
      chk({7'h0, ak}, 8'h00);
   endtask : setcmd
   task automatic pins_chk();
      repeat (10) @(posedge clk_in);
      chk(z_oe, ~reg_m[6]);
      chk(o_oe, ~reg_m[7]);
      chk(z_o & z_oe, reg_m[2] & ~reg_m[6]);
      chk(o_o & o_oe, reg_m[3] & ~reg_m[7]);
   endtask : pins_chk
   task automatic wr2(input logic [2:0] c, input logic [7:0] d0, input logic [7:0] d1);
      setcmd({5'h0, c});
      i_iox_master.xfer(d0, 1'b1, q, ak);
      chk({7'h0, ak}, 8'h00);
      i_iox_master.xfer(d1, 1'b1, q, ak);
      chk({7'h0, ak}, 8'h00);
      i_iox_master.stop();
      // input levels ignore writes, the rest fill the pair in turn
      if (c[2:1] != 2'b00) begin
         reg_m[c]        = d0;
         reg_m[c ^ 3'h1] = d1;
      end
      pins_chk();
   endtask : wr2
   task automatic rd2(input logic [7:0] x0, input logic [7:0] x1);
      addr(1'b1, DEV, 1'b1);
      i_iox_master.xfer(8'hff, 1'b0, q, ak);
      chk(q, x0);
      i_iox_master.xfer(8'hff, 1'b1, q, ak);
      chk(q, x1);
      i_iox_master.stop();
   endtask : rd2
   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      rst_in = 1'b1;
      e0     = 8'h33;
      e1     = 8'hc6;
      do_reset();
      #37;
      for (int c = 2; c < 8; c += 2) begin
         setcmd(8'(c));
         rd2(reg_m[c], reg_m[c + 1]);
      end
      // foreign straps, foreign fixed bits, general call
      addr(1'b0, {IOX_ADDR_FIXED, 3'b100}, 1'b0);
      i_iox_master.stop();
      addr(1'b0, 7'h65, 1'b0);
      i_iox_master.stop();
      addr(1'b0, 7'h00, 1'b0);
      i_iox_master.stop();
      wr2(3'h3, 8'h3c, 8'ha5);
      setcmd(8'h02);
      rd2(8'ha5, 8'h3c);
      wr2(3'h4, 8'hff, 8'h00);
      wr2(3'h6, 8'h0f, 8'hf0);
      setcmd(8'h08); // upper command bits do not select
      rd2(lvl(0, e0), lvl(1, e1));
      wr2(3'h0, 8'h55, 8'haa);
      rd2(lvl(0, e0), lvl(1, e1));
      @(posedge clk_in);
      #2 e1 = 8'h5a;
      setcmd(8'h01);
      rd2(lvl(1, e1), lvl(0, e0));
      // second reset in mid-run
      do_reset();
      pins_chk();
      setcmd(8'h06);
      rd2(8'hff, 8'hff);
      give_verdict();
   end
   // hang limit
   initial begin
      #3000000;
      failures++;
      give_verdict();
   end
endmodule : iox_core_bench
`default_nettype wire

// ### tb/iox_core_chk.sv
// concurrent checks on the io expander top ports
`timescale 1ns/1ps
`default_nettype none
module iox_core_chk
   import iox_pkg::*;
(
   input wire logic       clk_in,
   input wire logic       rst_in,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_out,
   input wire logic       addr_strap_bit0_in,
   input wire logic       addr_strap_bit1_in,
   input wire logic       addr_strap_bit2_in,
   input wire logic [7:0] port_zero_pins_oe_out,
   input wire logic [7:0] port_one_pins_oe_out
);
   logic       st_tog;
   logic       st_ack;
   logic       oe_rise;
   logic       hit;
   logic [4:0] nbit;
   logic [7:0] sh;
   // ************************************************
   // bus tracking: start toggle keeps one driver per flop
   // ************************************************
   always_ff @(negedge sda_in or posedge rst_in) begin
      if (rst_in) st_tog <= 1'b0;
      else if (scl_in) st_tog <= ~st_tog;
   end
   // rises since start, address byte kept until the next start
   always_ff @(posedge scl_in or posedge rst_in) begin
      if (rst_in) begin
         st_ack  <= 1'b0;
         oe_rise <= 1'b0;
         nbit    <= 5'h0;
         sh      <= 8'h00;
      end else begin
         st_ack  <= st_tog;
         oe_rise <= sda_oe_out;
         if (st_tog != st_ack) begin
            nbit <= 5'h1;
            sh   <= {sh[6:0], sda_in};
         end else begin
            if (nbit != 5'h1f) nbit <= nbit + 5'h1;
            if (nbit < 5'h8) sh <= {sh[6:0], sda_in};
         end
      end
   end
   assign hit = sh[7:1] == {IOX_ADDR_FIXED, addr_strap_bit2_in, addr_strap_bit1_in, addr_strap_bit0_in};
   property p_rst_pins;
      @(posedge clk_in) disable iff (rst_in)
      $fell(rst_in) |-> (port_zero_pins_oe_out == 8'h00 && port_one_pins_oe_out == 8'h00)[*4];
   endproperty
   a_rst_pins: assert property (p_rst_pins)
      else $error("pins driven after reset");
   property p_rst_sda;
      @(posedge clk_in) disable iff (rst_in) $fell(rst_in) |-> !sda_oe_out;
   endproperty
   a_rst_sda: assert property (p_rst_sda)
      else $error("sda pulled after reset");
   property p_sda_od;
      @(posedge clk_in) disable iff (rst_in) sda_oe_out |-> !sda_out;
   endproperty
   a_sda_od: assert property (p_sda_od)
      else $error("sda driven high");
   property p_sda_stable;
      @(negedge scl_in) disable iff (rst_in) sda_oe_out == oe_rise;
   endproperty
   a_sda_stable: assert property (p_sda_stable)
      else $error("sda moved while scl high");
   property p_addr_quiet;
      @(posedge scl_in) disable iff (rst_in) (nbit >= 5'h1 && nbit <= 5'h7) |-> !sda_oe_out;
   endproperty
   a_addr_quiet: assert property (p_addr_quiet)
      else $error("sda pulled during address");
   property p_addr_ack;
      @(posedge scl_in) disable iff (rst_in) nbit == 5'h8 |-> sda_oe_out == hit;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("address ack wrong");
   property p_cmd_ack;
      @(posedge scl_in) disable iff (rst_in) nbit == 5'h11 && hit && !sh[0] |-> sda_oe_out;
   endproperty
   a_cmd_ack: assert property (p_cmd_ack)
      else $error("command byte not acked");
   property p_data_ack;
      @(posedge scl_in) disable iff (rst_in) nbit == 5'h1a && hit && !sh[0] |-> sda_oe_out;
   endproperty
   a_data_ack: assert property (p_data_ack)
      else $error("data byte not acked");
   property p_rd_release;
      @(posedge scl_in) disable iff (rst_in) nbit == 5'h11 && hit && sh[0] |-> !sda_oe_out;
   endproperty
   a_rd_release: assert property (p_rd_release)
      else $error("sda held in master ack slot");
endmodule : iox_core_chk
bind iox_core iox_core_chk i_iox_core_chk (
   .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .addr_strap_bit0_in(addr_strap_bit0_in),
   .addr_strap_bit1_in(addr_strap_bit1_in), .addr_strap_bit2_in(addr_strap_bit2_in),
   .port_zero_pins_oe_out(port_zero_pins_oe_out), .port_one_pins_oe_out(port_one_pins_oe_out));
`default_nettype wire

// ### tb/iox_master.sv
// bus master model: scl and an open-drain pull on sda
`timescale 1ns/1ps
`default_nettype none
module iox_master (
   output var  logic scl_out,
   output var  logic sda_low_out,
   input  wire logic sda_in
);
   // both lines released; scl stands still outside frames
   initial begin
      scl_out     = 1'b1;
      sda_low_out = 1'b0;
   end
   // also a repeated start when entered with scl low
   task automatic start();
      #40 sda_low_out = 1'b0;
      #40 scl_out = 1'b1;
      #80 sda_low_out = 1'b1;
      #80 scl_out = 1'b0;
   endtask : start
   // data moves only while scl low
   task automatic bit_io(input logic b, output logic r);
      #40 sda_low_out = ~b;
      #40 scl_out = 1'b1;
      #40 r = sda_in;
      #40 scl_out = 1'b0;
   endtask : bit_io
   // msb first, then the ack slot; a 1 releases sda
   task automatic xfer(input logic [7:0] d, input logic am, output logic [7:0] q, output logic ar);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(am, ar);
   endtask : xfer
   task automatic stop();
      #40 sda_low_out = 1'b1;
      #40 scl_out = 1'b1;
      #80 sda_low_out = 1'b0;
   endtask : stop
endmodule : iox_master
`default_nettype wire
